/* src/iess_pkg.sv */
// shared constants, bus carrier and decode helpers for the internal error severity select block
package iess_pkg;

    // register bus geometry
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    // number of severity-controlled source positions (bit 3 is a hole)
    localparam int          NSRC          = 12;

    // register offsets (byte addresses)
    localparam logic [11:0] SEV_OFS       = 12'h48C;
    localparam logic [11:0] IRQ_STAT_OFS  = 12'h4A0;
    localparam logic [11:0] IRQ_CLR_OFS   = 12'h4A4;
    localparam logic [11:0] IRQ_EN_OFS    = 12'h4A8;

    // severity field positions
    localparam int          SEV_IN_POST   = 0;
    localparam int          SEV_IN_NPOST  = 1;
    localparam int          SEV_IN_CPL    = 2;
    localparam int          SEV_RSVD      = 3;
    localparam int          SEV_EG_POST   = 4;
    localparam int          SEV_EG_NPOST  = 5;
    localparam int          SEV_EG_CPL    = 6;
    localparam int          SEV_IN_DAT_SB = 7;
    localparam int          SEV_IN_DAT_DB = 8;
    localparam int          SEV_IN_CTL_SB = 9;
    localparam int          SEV_IN_CTL_DB = 10;
    localparam int          SEV_EG_DAT_SB = 11;

    // severity value after power-on reset: bits 0, 4, 8, 10 uncorrectable
    localparam logic [11:0] SEV_RST       = 12'h511;
    // writable severity bits; reserved bit 3 is excluded
    localparam logic [11:0] SEV_WMASK     = 12'hFF7;

    // interrupt status layout
    localparam int          IRQ_W         = 2;
    localparam int          IRQ_UNCOR_BIT = 0;
    localparam int          IRQ_COR_BIT   = 1;
    localparam logic [1:0]  IRQ_RST       = 2'h0;

    // one register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } iess_req_s;

    // per-source classification result
    typedef struct packed {
        logic [11:0] uncor;
        logic [11:0] cor;
    } iess_rpt_s;

    // address match for one register
    function automatic logic iess_hit(input logic [11:0] addr, input logic [11:0] ofs);
        iess_hit = (addr == ofs);
    endfunction : iess_hit

    // zero-extend a narrow register onto the data bus
    function automatic logic [31:0] iess_zext(input logic [11:0] v);
        iess_zext = {20'h00000, v};
    endfunction : iess_zext

endpackage : iess_pkg

/* src/iess_classify.sv */
// per-source split of logged, unmasked internal errors into uncorrectable and correctable
`timescale 1ns/1ps
`default_nettype none

module iess_classify
    import iess_pkg::*;
#(
    parameter int N = NSRC
) (
    input  wire logic [N-1:0] err_status,
    input  wire logic [N-1:0] err_mask,
    input  wire logic [N-1:0] sev,
    output iess_rpt_s         rpt
);

    logic [N-1:0] live;

    // a masked source never reports, its status bit is left untouched outside
    assign live      = err_status & ~err_mask;
    assign rpt.uncor = live & sev;
    assign rpt.cor   = live & ~sev;

endmodule : iess_classify

`default_nettype wire

/* src/iess_top.sv */
// severity select register, error classification and interrupt logic for internal error sources
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - severity one reports unmasked error uncorrectable
// - severity zero reports unmasked error correctable
// - masked errors produce no report at all
// - ingress timeouts bits 0-2, reset 1,0,0
// - egress timeouts bits 4-6, reset 1,0,0
// - ingress data bits 7,8 reset 0,1
// - ingress control bits 9,10 reset 0,1
// - egress data single-bit bit 11 resets 0
// - mask blocks report, status bit unchanged
module iess_top
    import iess_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        por_rstn,
    input  wire iess_req_s   bus_req,
    output logic [31:0]      rdata,
    input  wire logic [11:0] err_status,
    input  wire logic [11:0] err_mask,
    output logic [11:0]      uncor_src,
    output logic [11:0]      cor_src,
    output logic             uncor_err,
    output logic             cor_err,
    output logic             irq
);

    logic [11:0]      sev_ff;
    logic [11:0]      uncor_src_ff;
    logic [11:0]      cor_src_ff;
    logic             uncor_err_ff;
    logic             cor_err_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_en_ff;
    logic             irq_ff;
    logic [31:0]      rdata_ff;
    iess_rpt_s        rpt;
    logic             nxt_uncor_err;
    logic             nxt_cor_err;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] nxt_irq_stat;
    logic [IRQ_W-1:0] nxt_irq_en;
    logic             sev_wr;

    // split every logged, unmasked source by its severity bit
    iess_classify #(
        .N          (NSRC)
    ) u_classify (
        .err_status (err_status),
        .err_mask   (err_mask),
        .sev        (sev_ff),
        .rpt        (rpt)
    );

    assign sev_wr = bus_req.wr && iess_hit(bus_req.addr, SEV_OFS);

    // severity bits only see the power-on reset so a warm reset keeps the programming
    always_ff @(posedge clk) begin
        if (!por_rstn) begin
            sev_ff <= SEV_RST;
        end else if (sev_wr) begin
            sev_ff <= bus_req.wdata[11:0] & SEV_WMASK;
        end
    end

    assign nxt_uncor_err = |rpt.uncor;
    assign nxt_cor_err   = |rpt.cor;

    // registered reports toward the error reporting logic, one cycle behind the inputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            uncor_src_ff <= 12'h000;
            cor_src_ff   <= 12'h000;
            uncor_err_ff <= 1'b0;
            cor_err_ff   <= 1'b0;
        end else begin
            uncor_src_ff <= rpt.uncor;
            cor_src_ff   <= rpt.cor;
            uncor_err_ff <= nxt_uncor_err;
            cor_err_ff   <= nxt_cor_err;
        end
    end

    // a new report is the rising edge of a summary level; a held error does not re-interrupt
    assign irq_evt[IRQ_UNCOR_BIT] = nxt_uncor_err && !uncor_err_ff;
    assign irq_evt[IRQ_COR_BIT]   = nxt_cor_err && !cor_err_ff;
    assign irq_clr = (bus_req.wr && iess_hit(bus_req.addr, IRQ_CLR_OFS)) ? bus_req.wdata[IRQ_W-1:0] : IRQ_RST;
    // set beats clear so an event in the clearing cycle survives
    assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;
    // the line must follow a new enable at once, so it is built from the next enable value
    assign nxt_irq_en = (bus_req.wr && iess_hit(bus_req.addr, IRQ_EN_OFS)) ? bus_req.wdata[IRQ_W-1:0] : irq_en_ff;

    // sticky interrupt status and enable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_stat_ff <= IRQ_RST;
            irq_en_ff   <= IRQ_RST;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_en_ff   <= nxt_irq_en;
            irq_ff      <= |(nxt_irq_stat & nxt_irq_en);
        end
    end

    // read data stands only in the cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_ff <= 32'h00000000;
        end else if (bus_req.rd) begin
            if (iess_hit(bus_req.addr, SEV_OFS)) begin
                rdata_ff <= iess_zext(sev_ff & SEV_WMASK);
            end else if (iess_hit(bus_req.addr, IRQ_STAT_OFS)) begin
                rdata_ff <= {30'h0, irq_stat_ff};
            end else if (iess_hit(bus_req.addr, IRQ_EN_OFS)) begin
                rdata_ff <= {30'h0, irq_en_ff};
            end else begin
                rdata_ff <= 32'h00000000;                        // clear register is write-only
            end
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign rdata     = rdata_ff;
    assign uncor_src = uncor_src_ff;
    assign cor_src   = cor_src_ff;
    assign uncor_err = uncor_err_ff;
    assign cor_err   = cor_err_ff;
    assign irq       = irq_ff;

    // unmasked error with severity one shows as uncorrectable next cycle
    property p_uncor_report;
        @(posedge clk) disable iff (!rstn || !por_rstn)
        (|(err_status & ~err_mask & sev_ff)) |=> uncor_err;
    endproperty
    a_uncor_report: assert property (p_uncor_report) else $error("unmasked severe error not uncorrectable");

    // unmasked error with severity zero shows as correctable next cycle
    property p_cor_report;
        @(posedge clk) disable iff (!rstn || !por_rstn)
        (|(err_status & ~err_mask & ~sev_ff)) |=> cor_err;
    endproperty
    a_cor_report: assert property (p_cor_report) else $error("unmasked mild error not correctable");

    // nothing unmasked means no report of either kind
    property p_masked_silent;
        @(posedge clk) disable iff (!rstn)
        ((err_status & ~err_mask) == 12'h000) |=> (!uncor_err && !cor_err && uncor_src == 12'h000);
    endproperty
    a_masked_silent: assert property (p_masked_silent) else $error("report without unmasked error");

    // ingress timeout severities after power-on reset
    property p_rst_ingress_to;
        @(posedge clk) disable iff (!por_rstn)
        $rose(por_rstn) |-> (sev_ff[SEV_IN_CPL:SEV_IN_POST] == 3'h1);
    endproperty
    a_rst_ingress_to: assert property (p_rst_ingress_to) else $error("ingress timeout severity reset wrong");

    // egress timeout severities after power-on reset
    property p_rst_egress_to;
        @(posedge clk) disable iff (!por_rstn)
        $rose(por_rstn) |-> (sev_ff[SEV_EG_CPL:SEV_EG_POST] == 3'h1);
    endproperty
    a_rst_egress_to: assert property (p_rst_egress_to) else $error("egress timeout severity reset wrong");

    // ingress data severities after power-on reset
    property p_rst_in_data;
        @(posedge clk) disable iff (!por_rstn)
        $rose(por_rstn) |-> (sev_ff[SEV_IN_DAT_DB:SEV_IN_DAT_SB] == 2'h2);
    endproperty
    a_rst_in_data: assert property (p_rst_in_data) else $error("ingress data severity reset wrong");

    // ingress control severities after power-on reset
    property p_rst_in_ctl;
        @(posedge clk) disable iff (!por_rstn)
        $rose(por_rstn) |-> (sev_ff[SEV_IN_CTL_DB:SEV_IN_CTL_SB] == 2'h2);
    endproperty
    a_rst_in_ctl: assert property (p_rst_in_ctl) else $error("ingress control severity reset wrong");

    // egress data single-bit severity resets to zero and stays zero while two cycles pass without a write
    property p_eg_dat_sb;
        @(posedge clk) disable iff (!por_rstn)
        $rose(por_rstn) ##0 !sev_wr [*2] |-> !sev_ff[SEV_EG_DAT_SB];
    endproperty
    a_eg_dat_sb: assert property (p_eg_dat_sb) else $error("egress data severity not zero after reset");

    // a masked source never appears in either per-source report
    property p_mask_blocks;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> (((uncor_src | cor_src) & $past(err_mask)) == 12'h000);
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked source reported");

    // warm reset leaves severity alone, reserved bit stays zero
    property p_sticky;
        @(posedge clk) disable iff (!por_rstn)
        (!rstn && !sev_wr) |=> ($stable(sev_ff) && !sev_ff[SEV_RSVD]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("severity lost on warm reset");

    // interrupt level follows enabled sticky status
    property p_irq_level;
        @(posedge clk) disable iff (!rstn)
        (irq_stat_ff & irq_en_ff) != 2'h0 |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt low with enabled status");

endmodule : iess_top

`default_nettype wire

/* dv/iess_top_test.sv */
// self-checking testbench for the internal error severity select block
`timescale 1ns/1ps
`default_nettype none

module iess_top_test;
    import iess_pkg::*;

    logic        clk;
    logic        rstn;
    logic        por_rstn;
    iess_req_s   bus_req;
    logic [31:0] rdata;
    logic [11:0] err_status;
    logic [11:0] err_mask;
    logic [11:0] uncor_src;
    logic [11:0] cor_src;
    logic        uncor_err;
    logic        cor_err;
    logic        irq;
    int          num_errors;
    int          n_checks;

    iess_top iess_top_inst (
        .clk        (clk),
        .rstn       (rstn),
        .por_rstn   (por_rstn),
        .bus_req    (bus_req),
        .rdata      (rdata),
        .err_status (err_status),
        .err_mask   (err_mask),
        .uncor_src  (uncor_src),
        .cor_src    (cor_src),
        .uncor_err  (uncor_err),
        .cor_err    (cor_err),
        .irq        (irq)
    );

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic summarize();
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // one-cycle write strobe, released on the next edge
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        chk32(rdata, exp);
    endtask : rd_chk

    // drive status and mask, then compare the registered report one cycle later
    task automatic err_chk(input logic [11:0] st, input logic [11:0] mk, input logic [11:0] sv);
        logic [11:0] eu;
        logic [11:0] ec;
        eu = st & ~mk & sv & SEV_WMASK;
        ec = st & ~mk & ~(sv & SEV_WMASK);
        @(posedge clk);
        err_status <= st;
        err_mask   <= mk;
        @(posedge clk);
        #1;
        chk32({20'h0, uncor_src}, {20'h0, eu});
        chk32({20'h0, cor_src}, {20'h0, ec});
        chk32({31'h0, uncor_err}, {31'h0, |eu});
        chk32({31'h0, cor_err}, {31'h0, |ec});
    endtask : err_chk

    task automatic t_reset_values();
        rd_chk(SEV_OFS, 32'h0000_0511);
        rd_chk(IRQ_STAT_OFS, 32'h0);
        rd_chk(12'h490, 32'h0);
        wr_reg(SEV_OFS, 32'hFFFF_FFFF);
        rd_chk(SEV_OFS, 32'h0000_0FF7);
        wr_reg(SEV_OFS, 32'h0);
        rd_chk(SEV_OFS, 32'h0);
    endtask : t_reset_values

    // three severity patterns against open, partial and full masks
    task automatic t_classify();
        logic [11:0] sv [3] = '{12'h0F0, 12'hFFF, 12'h50A};
        logic [11:0] mk [3] = '{12'h000, 12'h102, 12'hFFF};
        for (int i = 0; i < 3; i++) begin
            wr_reg(SEV_OFS, {20'h0, sv[i]});
            for (int j = 0; j < 3; j++) begin
                err_chk(12'hFFF, mk[j], sv[i]);
            end
        end
        // enable still clear, so the interrupt line must stay low
        chk32({31'h0, irq}, 32'h0);
        err_chk(12'h000, 12'h000, 12'h50A);
    endtask : t_classify

    task automatic t_interrupt();
        wr_reg(IRQ_CLR_OFS, 32'h3);
        rd_chk(IRQ_STAT_OFS, 32'h0);
        wr_reg(SEV_OFS, 32'h0000_0001);
        wr_reg(IRQ_EN_OFS, 32'h3);
        rd_chk(IRQ_EN_OFS, 32'h3);
        err_chk(12'h003, 12'h000, 12'h001);
        rd_chk(IRQ_STAT_OFS, 32'h3);
        chk32({31'h0, irq}, 32'h1);
        err_chk(12'h000, 12'h000, 12'h001);
        wr_reg(IRQ_CLR_OFS, 32'h1);
        rd_chk(IRQ_STAT_OFS, 32'h2);
        chk32({31'h0, irq}, 32'h1);
        wr_reg(IRQ_EN_OFS, 32'h1);
        #1;
        chk32({31'h0, irq}, 32'h0);
        wr_reg(IRQ_CLR_OFS, 32'h2);
        rd_chk(IRQ_STAT_OFS, 32'h0);
        rd_chk(IRQ_CLR_OFS, 32'h0);
    endtask : t_interrupt

    // a warm reset alone must leave the severity pattern in place
    task automatic t_sticky();
        wr_reg(SEV_OFS, 32'h0000_0AAA);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(SEV_OFS, 32'h0000_0AA2);
        rd_chk(IRQ_EN_OFS, 32'h0);
    endtask : t_sticky

    // watchdog sized well past the hundred or so cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        summarize();
    end

    initial begin
        clk        = 1'b0;
        rstn       = 1'b0;
        por_rstn   = 1'b0;
        bus_req    = '0;
        err_status = 12'h000;
        err_mask   = 12'h000;
        num_errors = 0;
        n_checks   = 0;
        repeat (20) @(posedge clk);
        rstn     <= 1'b1;
        por_rstn <= 1'b1;
        t_reset_values();
        t_classify();
        t_interrupt();
        t_sticky();
        summarize();
    end

endmodule : iess_top_test

`default_nettype wire
